// ### rtl/pmf_pkg.sv
/*
 * pmf_pkg: register map, field positions, reset values and codes for the
 * timing message filter and configuration block.
 * Assumes a 32-bit AXI4-Lite slave; printed offsets are word indices.
 */
`default_nettype none

package pmf_pkg;
    localparam int PMF_AW = 16;

    // printed offsets are not all multiples of four: they are word indices
    localparam logic [11:0] PMF_I_ADJ = 12'h0612;
    localparam logic [11:0] PMF_I_DLO = 12'h0614;
    localparam logic [11:0] PMF_I_DHI = 12'h0616;
    localparam logic [11:0] PMF_I_CFG1 = 12'h0620;
    localparam logic [11:0] PMF_I_CFG2 = 12'h0622;
    localparam logic [11:0] PMF_I_DOM = 12'h0624;
    localparam logic [15:0] PMF_A_ADJ = {2'b00, PMF_I_ADJ, 2'b00};
    localparam logic [15:0] PMF_A_DLO = {2'b00, PMF_I_DLO, 2'b00};
    localparam logic [15:0] PMF_A_DHI = {2'b00, PMF_I_DHI, 2'b00};
    localparam logic [15:0] PMF_A_CFG1 = {2'b00, PMF_I_CFG1, 2'b00};
    localparam logic [15:0] PMF_A_CFG2 = {2'b00, PMF_I_CFG2, 2'b00};
    localparam logic [15:0] PMF_A_DOM = {2'b00, PMF_I_DOM, 2'b00};

    localparam logic [15:0] PMF_CFG1_RST = 16'h0059;
    localparam logic [15:0] PMF_CFG2_RST = 16'h0404;
    localparam logic [15:0] PMF_DOM_RST = 16'h0200;
    localparam logic [15:0] PMF_ZERO_RST = 16'h0000;
    localparam logic [15:0] PMF_CFG1_WM = 16'h00FF;
    localparam logic [15:0] PMF_CFG2_WM = 16'h1FB7;
    localparam logic [15:0] PMF_DOM_WM = 16'h0FFF;

    localparam int PMF_ADJ_DIR = 15;
    localparam int PMF_ADJ_EN = 14;
    localparam int PMF_C1_PTP = 6;
    localparam int PMF_C1_ETH = 5;
    localparam int PMF_C1_V4 = 4;
    localparam int PMF_C1_V6 = 3;
    localparam int PMF_C1_P2P = 2;
    localparam int PMF_C1_MST = 1;
    localparam int PMF_C1_ONE = 0;
    localparam int PMF_C2_UNI = 12;
    localparam int PMF_C2_ALT = 11;
    localparam int PMF_C2_PRIO = 10;
    localparam int PMF_C2_SFU = 9;
    localparam int PMF_C2_DLY = 8;
    localparam int PMF_C2_PDLY = 7;
    localparam int PMF_C2_DOM = 4;
    localparam int PMF_C2_CSUM = 2;
    localparam int PMF_C2_ANN = 1;

    localparam logic [3:0] PMF_T_SYNC = 4'h0;
    localparam logic [3:0] PMF_T_DREQ = 4'h1;
    localparam logic [3:0] PMF_T_EVT_END = 4'h4;
    localparam logic [3:0] PMF_T_PDRSP = 4'h3;
    localparam logic [3:0] PMF_T_FU = 4'h8;
    localparam logic [3:0] PMF_T_DRSP = 4'h9;
    localparam logic [3:0] PMF_T_PDFU = 4'hA;
    localparam logic [15:0] PMF_PORT_EVT = 16'h013F;
    localparam logic [15:0] PMF_PORT_GEN = 16'h0140;

    localparam logic [1:0] PMF_OKAY = 2'b00;
    localparam logic [1:0] PMF_SLVERR = 2'b10;

    typedef enum logic [1:0] {PMF_ENC_NONE, PMF_ENC_ETH, PMF_ENC_V4, PMF_ENC_V6} pmf_enc_e;
    typedef enum logic [1:0] {PMF_CS_KEEP, PMF_CS_RECALC, PMF_CS_ZERO} pmf_csum_e;
endpackage

`default_nettype wire

// ### rtl/pmf_filter.sv
/*
 * pmf_filter: AXI4-Lite register file, temporary rate adjustment timer and
 * per-message forwarding decision for the timing message engine.
 * Assumes a frame parser presents one parsed message per msg_valid cycle
 * and that ref_tick pulses once per 25 MHz reference clock cycle.
 */
// Behaviour
// [R01] high duration word gives bits 31..16 of duration, in reference cycles
// [R02] config one bit 6 enables protocol mode, set after reset
// [R03] config one bit 5 enables plain Ethernet message detection, clear after reset
// [R04] config one bit 4 enables IPv4/UDP message detection, set after reset
// [R05] config one bit 3 enables IPv6/UDP message detection, set after reset
// [R06] config one bit 2 selects peer-to-peer, else end-to-end transparent clock
// [R07] config one bit 1 makes host port master, else slave
// [R08] config one bit 0 selects one-step, else two-step; one-step at reset
// [R09] unicast on ports 319/320 with non-reserved address goes to table lookup
// [R10] alternate master on: same-domain master sync/followup/delay messages reach host
// [R11] alternate master off, host master: drop sync, still forward delay request
// [R12] config two bit 10: all messages high queue, else only event messages
// [R13] config two bit 9 associates followup with its sync
// [R14] bit 8: delay response forwarded only when it matches a request
// [R15] bit 7: peer delay responses from host port forwarded only on match
// [R16] domain check on: forward equal domain, drop others
// [R17] bit 2 set: recompute IPv4/UDP egress checksum, clear: write zero
// [R18] zero IPv4/UDP egress checksum stays zero
// [R19] IPv6/UDP egress checksum is always updated
// [R20] software sets bit 1 when announce arrives from network side
// [R21] domain value lives in domain register bits 7..0, reset zero
// [R22] adjustment enable clears itself when duration has elapsed
// [R23] low duration word gives bits 15..0 of duration
// [R24] reserved read-only config bits read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none

module pmf_filter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pmf_pkg::PMF_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pmf_pkg::PMF_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_tick,
    input wire logic msg_valid,
    input wire pmf_pkg::pmf_enc_e msg_enc,
    input wire logic [3:0] msg_type,
    input wire logic [7:0] msg_domain,
    input wire logic msg_from_net,
    input wire logic msg_from_master,
    input wire logic msg_unicast,
    input wire logic [15:0] msg_udp_port,
    input wire logic msg_reserved_addr,
    input wire logic msg_assoc_ok,
    input wire logic msg_egress,
    input wire logic msg_csum_zero,
    output logic res_valid,
    output logic res_ptp,
    output logic res_to_host,
    output logic res_drop,
    output logic res_lookup,
    output logic res_high_prio,
    output pmf_pkg::pmf_csum_e res_csum,
    output logic ptp_enable,
    output logic p2p_mode,
    output logic host_master,
    output logic one_step,
    output logic announce_from_net,
    output logic rate_dir,
    output logic temp_adj_active
);
    import pmf_pkg::*;

    logic [15:0] adj_r, dlo_r, dhi_r, cfg1_r, cfg2_r, dom_r;
    logic [31:0] cnt_r;
    logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [15:0] awaddr_r, wdata_r;
    logic [1:0] wstrb_r, bresp_r, rresp_r;
    logic [31:0] rdata_r;

    // write path: address and data are latched independently
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire do_wr = aw_got_r && w_got_r && !bvalid_r;
    wire [13:0] wa = awaddr_r[15:2];
    wire wr_adj = do_wr && (wa == PMF_A_ADJ[15:2]);
    wire wr_dlo = do_wr && (wa == PMF_A_DLO[15:2]);
    wire wr_dhi = do_wr && (wa == PMF_A_DHI[15:2]);
    wire wr_cfg1 = do_wr && (wa == PMF_A_CFG1[15:2]);
    wire wr_cfg2 = do_wr && (wa == PMF_A_CFG2[15:2]);
    wire wr_dom = do_wr && (wa == PMF_A_DOM[15:2]);
    wire wr_hit = wr_adj || wr_dlo || wr_dhi || wr_cfg1 || wr_cfg2 || wr_dom;
    wire [15:0] bmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] bm, input logic [15:0] wm);
        merge = (old & ~(bm & wm)) | (nw & bm & wm);
    endfunction

    wire [15:0] adj_nxt = merge(adj_r, wdata_r, bmask, 16'hFFFF);
    wire [15:0] cfg1_nxt = merge(cfg1_r, wdata_r, bmask, PMF_CFG1_WM); // R24
    wire [15:0] cfg2_nxt = merge(cfg2_r, wdata_r, bmask, PMF_CFG2_WM); // R24
    wire [15:0] dom_nxt = merge(dom_r, wdata_r, bmask, PMF_DOM_WM); // R21
    wire adj_start = wr_adj && adj_nxt[PMF_ADJ_EN];
    wire adj_done = adj_r[PMF_ADJ_EN] && ref_tick && (cnt_r <= 32'h0000_0001);

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= PMF_OKAY;
            awaddr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            wstrb_r <= 2'b00;
        end else begin
            if (aw_hs) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? PMF_OKAY : PMF_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dlo_r <= PMF_ZERO_RST;
            dhi_r <= PMF_ZERO_RST;
            cfg1_r <= PMF_CFG1_RST;
            cfg2_r <= PMF_CFG2_RST;
            dom_r <= PMF_DOM_RST;
        end else begin
            if (wr_dlo) begin
                dlo_r <= merge(dlo_r, wdata_r, bmask, 16'hFFFF);
            end
            if (wr_dhi) begin
                dhi_r <= merge(dhi_r, wdata_r, bmask, 16'hFFFF);
            end
            if (wr_cfg1) begin
                cfg1_r <= cfg1_nxt;
            end
            if (wr_cfg2) begin
                cfg2_r <= cfg2_nxt;
            end
            if (wr_dom) begin
                dom_r <= dom_nxt;
            end
        end
    end

    // adjustment timer; a software write in the expiry cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adj_r <= PMF_ZERO_RST;
            cnt_r <= 32'h0000_0000;
        end else if (wr_adj) begin
            adj_r <= adj_nxt;
            if (adj_start) begin
                cnt_r <= {dhi_r, dlo_r}; // R01 R23
            end
        end else if (adj_done) begin
            adj_r[PMF_ADJ_EN] <= 1'b0; // R22
            cnt_r <= 32'h0000_0000;
        end else if (adj_r[PMF_ADJ_EN] && ref_tick) begin
            cnt_r <= cnt_r - 32'h0000_0001;
        end
    end

    // read path, one answer in flight
    wire [13:0] ra = s_axi_araddr[15:2];
    wire rd_adj = (ra == PMF_A_ADJ[15:2]);
    wire rd_dlo = (ra == PMF_A_DLO[15:2]);
    wire rd_dhi = (ra == PMF_A_DHI[15:2]);
    wire rd_cfg1 = (ra == PMF_A_CFG1[15:2]);
    wire rd_cfg2 = (ra == PMF_A_CFG2[15:2]);
    wire rd_dom = (ra == PMF_A_DOM[15:2]);
    wire rd_hit = rd_adj || rd_dlo || rd_dhi || rd_cfg1 || rd_cfg2 || rd_dom;
    wire [15:0] rd_word = ({16{rd_adj}} & adj_r) | ({16{rd_dlo}} & dlo_r)
        | ({16{rd_dhi}} & dhi_r) | ({16{rd_cfg1}} & cfg1_r)
        | ({16{rd_cfg2}} & cfg2_r) | ({16{rd_dom}} & dom_r);

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= PMF_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_word};
            rresp_r <= rd_hit ? PMF_OKAY : PMF_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // mode outputs straight from the configuration bits
    assign ptp_enable = cfg1_r[PMF_C1_PTP]; // R02
    assign p2p_mode = cfg1_r[PMF_C1_P2P]; // R06
    assign host_master = cfg1_r[PMF_C1_MST]; // R07
    assign one_step = cfg1_r[PMF_C1_ONE]; // R08
    assign announce_from_net = cfg2_r[PMF_C2_ANN]; // R20
    assign rate_dir = adj_r[PMF_ADJ_DIR];
    assign temp_adj_active = adj_r[PMF_ADJ_EN];

    // message classification
    wire t_sync = (msg_type == PMF_T_SYNC);
    wire t_dreq = (msg_type == PMF_T_DREQ);
    wire t_fu = (msg_type == PMF_T_FU);
    wire t_drsp = (msg_type == PMF_T_DRSP);
    wire t_pd = (msg_type == PMF_T_PDRSP) || (msg_type == PMF_T_PDFU);
    wire t_event = (msg_type < PMF_T_EVT_END);
    wire enc_ok = ((msg_enc == PMF_ENC_ETH) && cfg1_r[PMF_C1_ETH]) // R03
        || ((msg_enc == PMF_ENC_V4) && cfg1_r[PMF_C1_V4]) // R04
        || ((msg_enc == PMF_ENC_V6) && cfg1_r[PMF_C1_V6]); // R05
    wire port_ok = (msg_udp_port == PMF_PORT_EVT) || (msg_udp_port == PMF_PORT_GEN);
    wire uni_ok = cfg2_r[PMF_C2_UNI] && port_ok && !msg_reserved_addr; // R09
    wire is_ptp = msg_valid && ptp_enable && enc_ok && (!msg_unicast || uni_ok);
    wire lookup = is_ptp && msg_unicast; // R09
    wire dom_eq = (msg_domain == dom_r[7:0]);
    wire dom_bad = cfg2_r[PMF_C2_DOM] && !dom_eq; // R16
    wire am_frame = msg_from_net && msg_from_master && dom_eq;
    // alternate master off, host master: sync dropped, delay request still goes through
    wire am_drop = am_frame && !cfg2_r[PMF_C2_ALT] && host_master && t_sync; // R11
    wire am_fwd = am_frame && (cfg2_r[PMF_C2_ALT] ? (t_sync || t_fu || t_dreq || t_drsp)
        : t_dreq); // R10 R11
    wire fu_bad = cfg2_r[PMF_C2_SFU] && t_fu && !msg_assoc_ok; // R13
    wire dr_bad = cfg2_r[PMF_C2_DLY] && t_drsp && !msg_assoc_ok; // R14
    wire pd_chk = cfg2_r[PMF_C2_PDLY] && !msg_from_net && t_pd;
    wire pd_bad = pd_chk && !msg_assoc_ok; // R15
    wire drop = is_ptp && !lookup && (dom_bad || am_drop || fu_bad || dr_bad || pd_bad);
    wire to_host = is_ptp && !lookup && !drop && (msg_from_net || am_fwd || pd_chk);
    wire hi_prio = is_ptp && (cfg2_r[PMF_C2_PRIO] || t_event); // R12
    wire eg_v4 = msg_egress && (msg_enc == PMF_ENC_V4);
    wire eg_v6 = msg_egress && (msg_enc == PMF_ENC_V6);
    pmf_csum_e csum_nxt;
    always_comb begin
        csum_nxt = PMF_CS_KEEP;
        if (eg_v6) begin
            csum_nxt = PMF_CS_RECALC; // R19
        end else if (eg_v4 && !msg_csum_zero) begin
            csum_nxt = cfg2_r[PMF_C2_CSUM] ? PMF_CS_RECALC : PMF_CS_ZERO; // R17 R18
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_valid <= 1'b0;
            res_ptp <= 1'b0;
            res_to_host <= 1'b0;
            res_drop <= 1'b0;
            res_lookup <= 1'b0;
            res_high_prio <= 1'b0;
            res_csum <= PMF_CS_KEEP;
        end else begin
            res_valid <= msg_valid;
            res_ptp <= is_ptp;
            res_to_host <= to_host;
            res_drop <= drop;
            res_lookup <= lookup;
            res_high_prio <= hi_prio;
            res_csum <= msg_valid ? csum_nxt : PMF_CS_KEEP;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_adj_clear;
        adj_r[PMF_ADJ_EN] && ref_tick && cnt_r == 32'h0000_0001 && !wr_adj
            |=> !temp_adj_active;
    endproperty
    a_adj_clear: assert property (p_adj_clear) else $error("adjust bit not cleared"); // R22

    property p_adj_load;
        adj_start |=> temp_adj_active && cnt_r == {dhi_r, dlo_r};
    endproperty
    a_adj_load: assert property (p_adj_load) else $error("duration not loaded"); // R01

    property p_cfg1_rsvd;
        rvalid_r && $rose(rvalid_r) && $past(rd_cfg1) |-> s_axi_rdata[15:8] == 8'h00;
    endproperty
    a_cfg1_rsvd: assert property (p_cfg1_rsvd) else $error("cfg1 reserved bits set"); // R24

    property p_cfg2_rsvd;
        $rose(rvalid_r) && $past(rd_cfg2) |->
            s_axi_rdata[15:13] == 3'b000 && !s_axi_rdata[6] && !s_axi_rdata[3];
    endproperty
    a_cfg2_rsvd: assert property (p_cfg2_rsvd) else $error("cfg2 reserved bits set"); // R24

    property p_dom_drop;
        is_ptp && !msg_unicast && cfg2_r[PMF_C2_DOM] && !dom_eq |=> res_drop && !res_to_host;
    endproperty
    a_dom_drop: assert property (p_dom_drop) else $error("wrong domain passed"); // R16

    property p_sync_drop;
        is_ptp && !msg_unicast && t_sync && am_frame && !cfg2_r[PMF_C2_ALT] && host_master
            |=> res_drop;
    endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("sync not dropped"); // R11

    property p_prio;
        msg_valid && !cfg2_r[PMF_C2_PRIO] && !t_event |=> !res_high_prio;
    endproperty
    a_prio: assert property (p_prio) else $error("general msg in high queue"); // R12

    property p_v4_zero;
        msg_valid && eg_v4 && !msg_csum_zero && !cfg2_r[PMF_C2_CSUM] |=> res_csum == PMF_CS_ZERO;
    endproperty
    a_v4_zero: assert property (p_v4_zero) else $error("checksum not zeroed"); // R17

    property p_v4_keep;
        msg_valid && eg_v4 && msg_csum_zero |=> res_csum == PMF_CS_KEEP;
    endproperty
    a_v4_keep: assert property (p_v4_keep) else $error("zero checksum changed"); // R18

    property p_v6;
        msg_valid && eg_v6 |=> res_csum == PMF_CS_RECALC;
    endproperty
    a_v6: assert property (p_v6) else $error("ipv6 checksum not updated"); // R19

    property p_uni;
        is_ptp && msg_unicast |=> res_lookup && !res_to_host && !res_drop;
    endproperty
    a_uni: assert property (p_uni) else $error("unicast not to lookup"); // R09

    property p_bresp;
        aw_hs && w_hs |-> ##2 s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write answer late");

    c_adj_done: cover property (adj_done && !wr_adj);
    c_fwd: cover property (res_valid && res_to_host);
    c_drop: cover property (res_valid && res_drop);
    c_rd: cover property (s_axi_rvalid && s_axi_rready && rresp_r == PMF_OKAY);
endmodule

`default_nettype wire

// ### testbench/pmf_msg_src.sv
/*
 * pmf_msg_src: frame parser model that presents one parsed timing message
 * per send() call on the msg_* inputs of the filter.
 * Assumes the caller owns the clock and that the filter takes every pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module pmf_msg_src (
    input wire logic aclk,
    output logic msg_valid,
    output pmf_pkg::pmf_enc_e msg_enc,
    output logic [3:0] msg_type,
    output logic [7:0] msg_domain,
    output logic msg_from_net,
    output logic msg_from_master,
    output logic msg_unicast,
    output logic [15:0] msg_udp_port,
    output logic msg_reserved_addr,
    output logic msg_assoc_ok,
    output logic msg_egress,
    output logic msg_csum_zero
);
    import pmf_pkg::*;

    initial begin
        msg_valid = 1'b0;
        msg_enc = PMF_ENC_NONE;
        {msg_type, msg_domain, msg_from_net, msg_from_master, msg_unicast} = '0;
        {msg_udp_port, msg_reserved_addr, msg_assoc_ok, msg_egress, msg_csum_zero} = '0;
    end

    task automatic send(input logic [36:0] v);
        @(posedge aclk);
        msg_valid <= 1'b1;
        msg_enc <= pmf_enc_e'(v[36:35]);
        {msg_type, msg_domain, msg_from_net, msg_from_master, msg_unicast} <= v[34:20];
        {msg_udp_port, msg_reserved_addr, msg_assoc_ok, msg_egress, msg_csum_zero} <= v[19:0];
        @(posedge aclk);
        msg_valid <= 1'b0;
        // stale fields other than msg_enc inverted so a filter reading them off-pulse is caught
        {msg_type, msg_domain, msg_from_net, msg_from_master, msg_unicast} <= ~v[34:20];
        {msg_udp_port, msg_reserved_addr, msg_assoc_ok, msg_egress, msg_csum_zero} <= ~v[19:0];
    endtask
endmodule

`default_nettype wire

// ### testbench/test_ptp_message_filter_config.sv
/*
 * test_ptp_message_filter_config: self-checking bench for pmf_filter.
 * Assumes the pmf_pkg register map and the message source model.
 */
`timescale 1ns/10ps
`default_nettype none

module test_ptp_message_filter_config;
    import pmf_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ref_tick = 1'b0;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, msg_type;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, msg_valid, msg_from_net, msg_from_master, msg_unicast;
    logic msg_reserved_addr, msg_assoc_ok, msg_egress, msg_csum_zero;
    logic [7:0] msg_domain;
    logic [15:0] msg_udp_port, m1, m2, md;
    pmf_enc_e msg_enc;
    pmf_csum_e res_csum;
    logic res_valid, res_ptp, res_to_host, res_drop, res_lookup, res_high_prio;
    logic ptp_enable, p2p_mode, host_master, one_step, announce_from_net, rate_dir;
    logic temp_adj_active;
    logic [6:0] rs;
    logic [4:0] lv;
    int fails = 0, checked = 0, seed = 40783;
    logic [33:0] exp_rd[$], exp_res[$];
    logic [31:0] w;
    logic [63:0] t64;
    logic [36:0] v;

    pmf_filter u_pmf_filter (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_tick,
        .msg_valid, .msg_enc, .msg_type, .msg_domain, .msg_from_net, .msg_from_master,
        .msg_unicast, .msg_udp_port, .msg_reserved_addr, .msg_assoc_ok, .msg_egress,
        .msg_csum_zero, .res_valid, .res_ptp, .res_to_host, .res_drop, .res_lookup,
        .res_high_prio, .res_csum, .ptp_enable, .p2p_mode, .host_master, .one_step,
        .announce_from_net, .rate_dir, .temp_adj_active);
    pmf_msg_src u_pmf_msg_src (.aclk, .msg_valid, .msg_enc, .msg_type, .msg_domain,
        .msg_from_net, .msg_from_master, .msg_unicast, .msg_udp_port, .msg_reserved_addr,
        .msg_assoc_ok, .msg_egress, .msg_csum_zero);

    assign rs = {res_ptp, res_to_host, res_drop, res_lookup, res_high_prio, res_csum};
    assign lv = {ptp_enable, p2p_mode, host_master, one_step, announce_from_net};

    always #25 aclk = ~aclk;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        check({32'h0, s_axi_bresp}, {32'h0, er});
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [15:0] a, input logic [33:0] e);
        exp_rd.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
    endtask

    // n sampled ticks, then settle to the falling edge before looking
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge aclk);
            ref_tick <= 1'b1;
        end
        @(posedge aclk);
        ref_tick <= 1'b0;
        @(negedge aclk);
    endtask

    function automatic logic [33:0] exp_dec(input logic [36:0] m);
        logic [3:0] t;
        logic net, uni, ok, ptp, mc, pd, drp;
        logic [1:0] cs;
        t = m[34:31];
        net = m[22];
        uni = m[20];
        ok = (m[36:35] == PMF_ENC_ETH && m1[5]) || (m[36:35] == PMF_ENC_V4 && m1[4]);
        ok = ok || (m[36:35] == PMF_ENC_V6 && m1[3]);
        ptp = m1[6] && ok && (!uni || (m2[12] && !m[3] &&
            (m[19:4] == PMF_PORT_EVT || m[19:4] == PMF_PORT_GEN)));
        mc = ptp && !uni;
        pd = !net && (t == PMF_T_PDRSP || t == PMF_T_PDFU);
        drp = (m2[4] && m[30:23] != md[7:0]) || (!m[2] && ((m2[9] && t == PMF_T_FU) ||
            (m2[8] && t == PMF_T_DRSP) || (m2[7] && pd)));
        drp = mc && (drp || (!m2[11] && m1[1] && t == PMF_T_SYNC && net && m[21] &&
            m[30:23] == md[7:0]));
        cs = PMF_CS_KEEP;
        if (m[1] && m[36:35] == PMF_ENC_V6) cs = PMF_CS_RECALC;
        if (m[1] && m[36:35] == PMF_ENC_V4 && !m[0]) cs = m2[2] ? PMF_CS_RECALC : PMF_CS_ZERO;
        return {27'h0, ptp, mc && !drp && (net || (m2[7] && pd)), drp, ptp && uni,
            ptp && (m2[10] || t < PMF_T_EVT_END), cs};
    endfunction

    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            check({s_axi_rresp, s_axi_rdata}, exp_rd.pop_front());
        end
        if (res_valid === 1'b1) begin
            check({27'h0, rs}, exp_res.pop_front());
        end
    end

    initial begin
        #4_000_000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(PMF_A_CFG1, {PMF_OKAY, 16'h0, PMF_CFG1_RST});
        axi_rd(PMF_A_CFG2, {PMF_OKAY, 16'h0, PMF_CFG2_RST});
        axi_rd(PMF_A_DOM, {PMF_OKAY, 16'h0, PMF_DOM_RST});
        axi_rd(PMF_A_DHI, {PMF_OKAY, 32'h0});
        axi_rd(16'h1860, {PMF_SLVERR, 32'h0});
        axi_wr(16'h1860, 32'hFFFF_FFFF, PMF_SLVERR);
        check({29'h0, lv}, 34'h0000_0012);
        $display("test reset values done");
        axi_wr(PMF_A_DLO, 32'h0000_0003, PMF_OKAY);
        axi_wr(PMF_A_ADJ, 32'h0000_4000, PMF_OKAY);
        ticks(2);
        check({33'h0, temp_adj_active}, 34'h1);
        ticks(1);
        check({33'h0, temp_adj_active}, 34'h0);
        axi_wr(PMF_A_DLO, 32'h0000_0000, PMF_OKAY);
        axi_wr(PMF_A_DHI, 32'h0000_0001, PMF_OKAY);
        axi_wr(PMF_A_ADJ, 32'h0000_C000, PMF_OKAY);
        ticks(65535);
        check({32'h0, rate_dir, temp_adj_active}, 34'h3);
        ticks(1);
        check({33'h0, temp_adj_active}, 34'h0);
        axi_rd(PMF_A_ADJ, {PMF_OKAY, 32'h0000_8000});
        $display("test adjust timer done");
        for (int r = 0; r < 6; r++) begin
            w = $random(seed);
            w[6] = w[6] | (r != 0);
            w[1] = w[1] | (r == 1);
            axi_wr(PMF_A_CFG1, w, PMF_OKAY);
            m1 = w[15:0] & PMF_CFG1_WM;
            axi_rd(PMF_A_CFG1, {PMF_OKAY, 16'h0, m1});
            w = $random(seed);
            w[11] = w[11] & (r != 1);
            axi_wr(PMF_A_CFG2, w, PMF_OKAY);
            m2 = w[15:0] & PMF_CFG2_WM;
            axi_rd(PMF_A_CFG2, {PMF_OKAY, 16'h0, m2});
            w = $random(seed);
            axi_wr(PMF_A_DOM, w, PMF_OKAY);
            md = w[15:0] & PMF_DOM_WM;
            axi_rd(PMF_A_DOM, {PMF_OKAY, 16'h0, md});
            check({29'h0, lv}, {29'h0, m1[6], m1[2], m1[1], m1[0], m2[1]});
            repeat (40) begin
                t64 = {$random(seed), $random(seed)};
                v = t64[36:0];
                if (t64[63]) v[30:23] = md[7:0];
                if (t64[62]) v[19:4] = t64[61] ? PMF_PORT_EVT : PMF_PORT_GEN;
                // same-domain sync from the net master, else almost never drawn
                if (t64[60] && t64[59]) v[34:20] = {PMF_T_SYNC, md[7:0], 3'b110};
                exp_res.push_back(exp_dec(v));
                u_pmf_msg_src.send(v);
            end
            $display("test message round %0d done", r);
        end
        repeat (3) @(posedge aclk);
        check(34'(exp_res.size()), 34'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
